/* shared/pps_params.svh */
// Overview of operation
// - reconfiguration raises phase_req one cycle after divider 0 applies
// - eight-bit high and low counts, reloadable
// - bypass gives vco divided by one
// - divide by high plus low counts
// - duty cycle follows count ratio
// - high-to-low on rising edge normally
// - counts 2 and 1 give two-thirds high
// - odd-divide moves fall to falling edge
// - odd-divide: high half shorter, low longer
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
`define PPS_NUM_DIV   5
`define PPS_CNT_W     8
`define PPS_CNT_ONE   8'h01
`define PPS_CNT_RST   8'h01
`endif

/* shared/pps_pkg.sv */
`include "pps_params.svh"
package pps_pkg;
	typedef struct packed {
		logic [`PPS_CNT_W-1:0] high_count;
		logic [`PPS_CNT_W-1:0] low_count;
		logic                  bypass;
		logic                  odd_divide_half_cycle_bit;
	} pps_cfg_t;
	typedef enum logic [0:0] {
		PPS_HIGH = 1'b0,
		PPS_LOW  = 1'b1
	} pps_phase_t;
endpackage

/* hw/pps_post_scale.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pps_params.svh"
module pps_post_scale
	import pps_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	input  wire pps_cfg_t               cfg_in    [`PPS_NUM_DIV],
	input  wire logic [`PPS_NUM_DIV-1:0] cfg_load,
	output var  logic [`PPS_NUM_DIV-1:0] div_out,
	output var  logic [`PPS_NUM_DIV-1:0] cfg_applied
);
	// ==========================================================
	// output_divider_0_to_4, clocked by the vco (core_clk)
	// ==========================================================
	// phase shift lives on a separate interface; no port here
	pps_cfg_t                pend_reg   [`PPS_NUM_DIV];
	pps_cfg_t                pend_next  [`PPS_NUM_DIV];
	pps_cfg_t                act_reg    [`PPS_NUM_DIV];
	pps_cfg_t                act_next   [`PPS_NUM_DIV];
	logic [`PPS_NUM_DIV-1:0] dirty_reg;
	logic [`PPS_NUM_DIV-1:0] dirty_next;
	pps_phase_t              phase_reg  [`PPS_NUM_DIV];
	pps_phase_t              phase_next [`PPS_NUM_DIV];
	logic [`PPS_CNT_W-1:0]   cnt_reg    [`PPS_NUM_DIV];
	logic [`PPS_CNT_W-1:0]   cnt_next   [`PPS_NUM_DIV];
	logic [`PPS_NUM_DIV-1:0] bnd_next;
	logic [`PPS_NUM_DIV-1:0] take_next;
	logic [`PPS_NUM_DIV-1:0] lvl_reg;
	logic [`PPS_NUM_DIV-1:0] lvl_next;
	logic [`PPS_NUM_DIV-1:0] dly_reg;
	logic [`PPS_NUM_DIV-1:0] dly_next;
	logic [`PPS_NUM_DIV-1:0] half_reg;
	logic [`PPS_NUM_DIV-1:0] half_next;
	logic [`PPS_NUM_DIV-1:0] applied_next;

	// zero count treated as one
	function automatic logic [`PPS_CNT_W-1:0] safe_cnt(
		input logic [`PPS_CNT_W-1:0] c);
		safe_cnt = (c == 8'h00) ? `PPS_CNT_ONE : c;
	endfunction

	// last cycle of a phase
	function automatic logic last_cnt(
		input logic [`PPS_CNT_W-1:0] c);
		last_cnt = (c <= `PPS_CNT_ONE);
	endfunction

	// ==========================================================
	// period boundary: last cycle of the low phase
	// ==========================================================
	always_comb
	begin
		for (int i = 0; i < `PPS_NUM_DIV; i++)
		begin
			bnd_next[i]  = (phase_reg[i] == PPS_LOW) && last_cnt(cnt_reg[i]);
			take_next[i] = bnd_next[i] && dirty_reg[i] && !cfg_load[i];
		end
	end

	// ==========================================================
	// pending settings, last load wins
	// ==========================================================
	always_comb
	begin
		for (int i = 0; i < `PPS_NUM_DIV; i++)
		begin
			pend_next[i]  = pend_reg[i];
			dirty_next[i] = dirty_reg[i];
			if (take_next[i])
				dirty_next[i] = 1'b0;
			if (cfg_load[i])
			begin
				pend_next[i]  = cfg_in[i];
				dirty_next[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < `PPS_NUM_DIV; i++)
				pend_reg[i] <= '0;
			dirty_reg <= '0;
		end
		else
		begin
			pend_reg  <= pend_next;
			dirty_reg <= dirty_next;
		end
	end

	// ==========================================================
	// active settings, swapped only at a period boundary
	// ==========================================================
	always_comb
	begin
		for (int i = 0; i < `PPS_NUM_DIV; i++)
		begin
			act_next[i]     = act_reg[i];
			applied_next[i] = take_next[i];
			if (take_next[i])
				act_next[i] = pend_reg[i];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < `PPS_NUM_DIV; i++)
				act_reg[i] <= '0;
			cfg_applied <= '0;
		end
		else
		begin
			act_reg     <= act_next;
			cfg_applied <= applied_next;
		end
	end

	// ==========================================================
	// high and low phase counter
	// ==========================================================
	always_comb
	begin
		for (int i = 0; i < `PPS_NUM_DIV; i++)
		begin
			phase_next[i] = phase_reg[i];
			cnt_next[i]   = cnt_reg[i] - `PPS_CNT_ONE;
			case (phase_reg[i])
				PPS_HIGH:
				begin
					if (last_cnt(cnt_reg[i]))
					begin
						phase_next[i] = PPS_LOW;
						cnt_next[i]   = safe_cnt(act_reg[i].low_count);
					end
				end
				PPS_LOW:
				begin
					if (last_cnt(cnt_reg[i]))
					begin
						phase_next[i] = PPS_HIGH;
						cnt_next[i]   = safe_cnt(act_next[i].high_count);
					end
				end
				default:
				begin
					phase_next[i] = PPS_LOW;
					cnt_next[i]   = `PPS_CNT_RST;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < `PPS_NUM_DIV; i++)
			begin
				phase_reg[i] <= PPS_LOW;
				cnt_reg[i]   <= `PPS_CNT_RST;
			end
		end
		else
		begin
			phase_reg <= phase_next;
			cnt_reg   <= cnt_next;
		end
	end

	// ==========================================================
	// registered output level
	// ==========================================================
	always_comb
	begin
		for (int i = 0; i < `PPS_NUM_DIV; i++)
			lvl_next[i] = (phase_next[i] == PPS_HIGH);
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			lvl_reg <= '0;
		else
			lvl_reg <= lvl_next;
	end

	// ==========================================================
	// level one vco cycle late, odd path rise
	// ==========================================================
	always_comb
	begin
		dly_next = lvl_reg;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			dly_reg <= '0;
		else
			dly_reg <= dly_next;
	end

	// ==========================================================
	// level half a vco cycle late, odd path fall
	// ==========================================================
	always_comb
	begin
		half_next = lvl_reg;
	end

	always_ff @(negedge core_clk)
	begin
		if (srst)
			half_reg <= '0;
		else
			half_reg <= half_next;
	end

	// ==========================================================
	// output select
	// ==========================================================
	always_comb
	begin
		for (int i = 0; i < `PPS_NUM_DIV; i++)
		begin
			if (act_reg[i].bypass)
				div_out[i] = core_clk;
			else if (act_reg[i].odd_divide_half_cycle_bit)
				div_out[i] = dly_reg[i] & half_reg[i];
			else
				div_out[i] = lvl_reg[i];
		end
	end
endmodule
`default_nettype wire

/* testbench/pps_chk.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pps_params.svh"
// ====
// load and apply checks
module pps_chk
	import pps_pkg::*;
(
	input wire logic                    core_clk,
	input wire logic                    srst,
	input wire pps_cfg_t                cfg_in [`PPS_NUM_DIV],
	input wire logic [`PPS_NUM_DIV-1:0] cfg_load,
	input wire logic [`PPS_NUM_DIV-1:0] div_out,
	input wire logic [`PPS_NUM_DIV-1:0] cfg_applied
);
	logic        pend_reg;
	logic        pend_next;
	logic [10:0] wait_reg;
	logic [10:0] wait_next;
	pps_cfg_t    load_reg;
	pps_cfg_t    cur_cfg_reg;
	pps_cfg_t    cur_cfg;
	logic [8:0]  run_reg;
	logic [8:0]  run_next;
	logic        last_reg;
	logic        plain_mode;
	logic [7:0]  exp_high;
	logic [7:0]  exp_low;
	function automatic logic [7:0] eff_cnt(input logic [7:0] c);
		eff_cnt = (c == 8'h00) ? 8'h01 : c;
	endfunction
	always_comb
	begin
		pend_next  = cfg_load[0] | (pend_reg & !cfg_applied[0]);
		if (cfg_load[0])
			wait_next = 11'h001;
		else if (pend_reg & !cfg_applied[0])
			wait_next = wait_reg + 11'h001;
		else
			wait_next = 11'h000;
		cur_cfg    = cfg_applied[0] ? load_reg : cur_cfg_reg;
		plain_mode = !cur_cfg.bypass && !cur_cfg.odd_divide_half_cycle_bit;
		exp_high   = eff_cnt(cur_cfg.high_count);
		exp_low    = eff_cnt(cur_cfg.low_count);
		if (cfg_applied[0] || (div_out[0] != last_reg))
			run_next = 9'h001;
		else
			run_next = run_reg + 9'h001;
	end
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			pend_reg    <= 1'b0;
			wait_reg    <= '0;
			load_reg    <= '0;
			cur_cfg_reg <= '0;
			run_reg     <= '0;
			last_reg    <= 1'b0;
		end
		else
		begin
			pend_reg    <= pend_next;
			wait_reg    <= wait_next;
			if (cfg_load[0])
				load_reg <= cfg_in[0];
			cur_cfg_reg <= cur_cfg;
			run_reg     <= run_next;
			last_reg    <= div_out[0];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	appl_cause_a: assert property (cfg_applied[0] |-> pend_reg)
		else $error("applied without load");
	appl_pulse_a: assert property (cfg_applied[0] |=> !cfg_applied[0])
		else $error("applied too long");
	appl_bound_a: assert property (wait_reg <= 11'h44c)
		else $error("load never applied");
	appl_rise_a: assert property (
		cfg_applied[0] && plain_mode |-> div_out[0])
		else $error("new period did not start high");
	high_time_a: assert property (
		plain_mode && last_reg && !div_out[0] |-> run_reg == {1'b0, exp_high})
		else $error("high time wrong");
	low_time_a: assert property (
		plain_mode && !last_reg && div_out[0] && !cfg_applied[0]
		|-> run_reg == {1'b0, exp_low})
		else $error("low time wrong");
endmodule
bind pps_post_scale pps_chk u_chk (.core_clk(core_clk), .srst(srst),
	.cfg_in(cfg_in), .cfg_load(cfg_load), .div_out(div_out),
	.cfg_applied(cfg_applied));
`default_nettype wire

/* testbench/pps_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// fabric side load driver
module pps_host (
	input  wire logic       core_clk,
	input  wire logic       go,
	input  wire logic       applied,
	output var  logic [4:0] cfg_load,
	output var  logic       phase_req
);
	// go registered onto all five cfg_load strobes; phase_req follows applied one cycle late
	always_ff @(posedge core_clk) cfg_load <= {5{go}};
	always_ff @(posedge core_clk) phase_req <= applied;
endmodule
`default_nettype wire

/* testbench/pps_post_scale_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pps_params.svh"
// ====
// bench
module pps_post_scale_test
	import pps_pkg::*;
;
	logic                    core_clk = 0;
	logic                    srst = 1;
	logic                    go = 0;
	logic                    phase_req;
	pps_cfg_t                cfg_in [`PPS_NUM_DIV];
	logic [`PPS_NUM_DIV-1:0] cfg_load;
	logic [`PPS_NUM_DIV-1:0] div_out;
	logic [`PPS_NUM_DIV-1:0] cfg_applied;
	int                      mismatches = 0;
	int                      compares = 0;
	int                      q[$];
	int                      exp_hi;
	int                      exp_lo;
	realtime                 t0, t1, t2;
	pps_post_scale dut (.core_clk(core_clk), .srst(srst), .cfg_in(cfg_in),
		.cfg_load(cfg_load), .div_out(div_out), .cfg_applied(cfg_applied));
	pps_host host (.core_clk(core_clk), .go(go), .applied(cfg_applied[0]),
		.cfg_load(cfg_load), .phase_req(phase_req));
	initial forever #50 core_clk = ~core_clk;
	task close_out;
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic ok);
		compares++;
		if (!ok)
		begin
			mismatches++;
			$display("Error %0t: divider output mismatch", $realtime);
		end
	endtask
	task ld(input int h, input int l, input int b, input int o);
		int n;
		foreach (cfg_in[i]) cfg_in[i] = '{h[7:0], l[7:0], b[0], o[0]};
		go = 1;
		@(posedge core_clk);
		#1 go = 0;
		q.push_back(b ? 50 : h * 100 - o * 50);
		q.push_back(b ? 50 : l * 100 + o * 50);
		n = 0;
		while (q.size() != 0 && n < 400)
		begin
			@(posedge core_clk);
			n++;
		end
		if (q.size() != 0)
		begin
			mismatches++;
			$display("Error %0t: settings never applied", $realtime);
			close_out;
		end
		@(posedge core_clk);
		#1;
	endtask
	initial forever
	begin
		@(negedge core_clk);
		if (cfg_applied[0] === 1'b1)
		begin
			@(negedge core_clk);
			chk(phase_req === 1'b1);
			@(posedge div_out[0]) t0 = $realtime;
			@(negedge div_out[0]) t1 = $realtime;
			@(posedge div_out[0]) t2 = $realtime;
			if (q.size() < 2)
				q = '{-1, -1};
			exp_hi = q.pop_front();
			exp_lo = q.pop_front();
			chk(t1 - t0 == exp_hi);
			chk(t2 - t1 == exp_lo);
			#1 chk(div_out === {`PPS_NUM_DIV{div_out[0]}});
		end
	end
	initial
	begin
		foreach (cfg_in[i]) cfg_in[i] = '0;
		void'($urandom(27580));
		repeat (8) @(posedge core_clk);
		#1 srst = 0;
		ld(4, 6, 0, 0);
		ld(2, 1, 0, 0);
		ld(2, 1, 0, 1);
		ld(3, 3, 1, 0);
		repeat (4) ld($urandom_range(8, 1), $urandom_range(8, 1), 0,
			$urandom_range(1));
		close_out;
	end
	initial
	begin
		#1ms mismatches++;
		close_out;
	end
endmodule
`default_nettype wire
